// >>> rtl/blrt_transceiver.sv
// Top level: two transceiver directions controlled over an AXI4-Lite slave
`timescale 1ns/1ns
module blrt_transceiver
  import blrt_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [AXI_SW-1:0] s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic      [AXI_DW-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // A bus pins
  input  wire logic [DATA_W-1:0] a_in,
  output logic      [DATA_W-1:0] a_out,
  output logic      [DATA_W-1:0] a_oe,
  // B bus pins
  input  wire logic [DATA_W-1:0] b_in,
  output logic      [DATA_W-1:0] b_out,
  output logic      [DATA_W-1:0] b_oe
);

  // Bus state
  blrt_wr_state_t    wr_state;
  blrt_rd_state_t    rd_state;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [AXI_DW-1:0] rdata_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [AXI_DW-1:0] wdata_reg;
  logic [AXI_SW-1:0] wstrb_reg;

  // Control and direction state
  logic [AXI_DW-1:0] ctrl_reg;
  logic [AXI_DW-1:0] ctrl_next;
  logic [AXI_DW-1:0] strb_mask;
  logic [DATA_W-1:0] ab_store;
  logic [DATA_W-1:0] ba_store;
  logic [DATA_W-1:0] ab_dout;
  logic [DATA_W-1:0] ba_dout;
  logic              ab_oe;
  logic              ba_oe;

  // Decode and selection
  blrt_sel_t         wr_sel;
  blrt_sel_t         rd_sel;
  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic              ctrl_write;
  logic              ar_take;
  logic [AXI_DW-1:0] rd_word;
  logic [1:0]        rd_resp;
  logic              a_to_b_output_enable_n;
  logic              a_to_b_latch_enable;
  logic              a_to_b_clock_n;
  logic              a_to_b_clock_enable_n;
  logic              b_to_a_output_enable_n;
  logic              b_to_a_latch_enable;
  logic              b_to_a_clock_n;
  logic              b_to_a_clock_enable_n;

  assign a_to_b_output_enable_n = ctrl_reg[LANE_AB + F_OE_N];
  assign a_to_b_latch_enable    = ctrl_reg[LANE_AB + F_LE];
  assign a_to_b_clock_n         = ctrl_reg[LANE_AB + F_CLK_N];
  assign a_to_b_clock_enable_n  = ctrl_reg[LANE_AB + F_CEN_N];
  assign b_to_a_output_enable_n = ctrl_reg[LANE_BA + F_OE_N];
  assign b_to_a_latch_enable    = ctrl_reg[LANE_BA + F_LE];
  assign b_to_a_clock_n         = ctrl_reg[LANE_BA + F_CLK_N];
  assign b_to_a_clock_enable_n  = ctrl_reg[LANE_BA + F_CEN_N];

  // Address and data may arrive in either order; both are held until the write fires
  assign aw_take    = s_axi_awvalid & awready_reg;
  assign w_take     = s_axi_wvalid & wready_reg;
  assign wr_sel     = blrt_decode(awaddr_reg);
  assign wr_fire    = (wr_state == WR_IDLE) & aw_got_reg & w_got_reg;
  assign ctrl_write = wr_fire & (wr_sel == SEL_CTRL);
  assign strb_mask  = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  // Reserved control bits never store, so they read back as zero
  assign ctrl_next  = ((ctrl_reg & ~strb_mask) | (wdata_reg & strb_mask)) & CTRL_MASK;

  assign ar_take = s_axi_arvalid & arready_reg;
  assign rd_sel  = blrt_decode(s_axi_araddr);
  assign rd_word = (rd_sel == SEL_CTRL)     ? ctrl_reg :
                   (rd_sel == SEL_AB_STORE) ? {{(AXI_DW-DATA_W){1'b0}}, ab_store} :
                   (rd_sel == SEL_BA_STORE) ? {{(AXI_DW-DATA_W){1'b0}}, ba_store} :
                   (rd_sel == SEL_A_PINS)   ? {{(AXI_DW-DATA_W){1'b0}}, a_in} :
                   (rd_sel == SEL_B_PINS)   ? {{(AXI_DW-DATA_W){1'b0}}, b_in} :
                   {AXI_DW{1'b0}};
  assign rd_resp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state    <= WR_IDLE;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= {AXI_AW{1'b0}};
      wdata_reg   <= {AXI_DW{1'b0}};
      wstrb_reg   <= {AXI_SW{1'b0}};
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (aw_take) begin
            aw_got_reg  <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
            awready_reg <= 1'b0;
          end else if (!aw_got_reg) begin
            awready_reg <= 1'b1;
          end
          if (w_take) begin
            w_got_reg  <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
            wready_reg <= 1'b0;
          end else if (!w_got_reg) begin
            wready_reg <= 1'b1;
          end
          if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            // Writes to read-only words are dropped but acknowledged
            bresp_reg  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            wr_state   <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            wr_state    <= WR_IDLE;
          end
        end
        default: begin
          wr_state <= WR_IDLE;
        end
      endcase
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state    <= RD_IDLE;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= {AXI_DW{1'b0}};
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_word;
            rresp_reg   <= rd_resp;
            rd_state    <= RD_DATA;
          end else begin
            arready_reg <= 1'b1;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
            rd_state    <= RD_IDLE;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // Control word; clock and latch fields are software-driven levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl_reg <= ctrl_next;
    end
  end

  blrt_direction u_a_to_b (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .latch_enable    (a_to_b_latch_enable),
    .clock_n         (a_to_b_clock_n),
    .clock_enable_n  (a_to_b_clock_enable_n),
    .output_enable_n (a_to_b_output_enable_n),
    .din             (a_in),
    .dout_reg        (ab_dout),
    .oe_reg          (ab_oe),
    .store_reg       (ab_store)
  );

  blrt_direction u_b_to_a (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .latch_enable    (b_to_a_latch_enable),
    .clock_n         (b_to_a_clock_n),
    .clock_enable_n  (b_to_a_clock_enable_n),
    .output_enable_n (b_to_a_output_enable_n),
    .din             (b_in),
    .dout_reg        (ba_dout),
    .oe_reg          (ba_oe),
    .store_reg       (ba_store)
  );

  // Pins; enabling both directions at once makes the two buses fight
  assign b_out = ab_dout;
  assign a_out = ba_dout;
  assign b_oe  = {DATA_W{ab_oe}};
  assign a_oe  = {DATA_W{ba_oe}};

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  property p_pin_pass;
    @(posedge aclk) disable iff (!aresetn)
      (a_to_b_latch_enable && !a_to_b_output_enable_n) |=> (b_out == $past(a_in)) && (b_oe == {DATA_W{1'b1}});
  endproperty
  a_pin_pass: assert property (p_pin_pass) else $error("B pins do not follow A");

  property p_pin_float;
    @(posedge aclk) disable iff (!aresetn)
      b_to_a_output_enable_n |=> (a_oe == {DATA_W{1'b0}});
  endproperty
  a_pin_float: assert property (p_pin_float) else $error("A pins driven while disabled");

  property p_independent;
    @(posedge aclk) disable iff (!aresetn)
      (!a_to_b_latch_enable && a_to_b_clock_enable_n && ctrl_write
        && (ctrl_next[LANE_AB + F_CEN_N:LANE_AB] == ctrl_reg[LANE_AB + F_CEN_N:LANE_AB])) |=> ##1 $stable(ab_store);
  endproperty
  a_independent: assert property (p_independent) else $error("B-to-A write disturbed A-to-B storage");

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
      ar_take |=> s_axi_rvalid && (s_axi_rresp == $past(rd_resp)) && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

endmodule // blrt_transceiver

// >>> include/blrt_pkg.sv
// Constants, types and address decode for the bidirectional latch/register transceiver
package blrt_pkg;

  // Data path width per direction
  localparam int DATA_W = 18;

  // AXI4-Lite geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = 4;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_AB_STORE = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_BA_STORE = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_A_PINS   = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_B_PINS   = 8'h10;

  // Control field positions inside one direction lane
  localparam int F_OE_N  = 0;
  localparam int F_LE    = 1;
  localparam int F_CLK_N = 2;
  localparam int F_CEN_N = 3;

  // Lane base bits: A-to-B in byte 0, B-to-A in byte 1
  localparam int LANE_AB = 0;
  localparam int LANE_BA = 8;

  // Outputs off, clock idle high, clock gated off after reset
  localparam logic [AXI_DW-1:0] CTRL_RESET = 32'h0000_0d0d;
  localparam logic [AXI_DW-1:0] CTRL_MASK  = 32'h0000_0f0f;

  // Storage and pin reset values
  localparam logic [DATA_W-1:0] STORE_RESET  = 18'h00000;
  localparam logic              CLK_N_RESET  = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register selection
  typedef enum logic [2:0] {
    SEL_NONE     = 3'h0,
    SEL_CTRL     = 3'h1,
    SEL_AB_STORE = 3'h2,
    SEL_BA_STORE = 3'h3,
    SEL_A_PINS   = 3'h4,
    SEL_B_PINS   = 3'h5
  } blrt_sel_t;

  // Bus channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } blrt_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } blrt_rd_state_t;

  // Word-aligned decode shared by the read and write paths
  function automatic blrt_sel_t blrt_decode(input logic [AXI_AW-1:0] addr);
    blrt_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      OFS_CTRL:     sel = SEL_CTRL;
      OFS_AB_STORE: sel = SEL_AB_STORE;
      OFS_BA_STORE: sel = SEL_BA_STORE;
      OFS_A_PINS:   sel = SEL_A_PINS;
      OFS_B_PINS:   sel = SEL_B_PINS;
      default:      sel = SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

// >>> rtl/blrt_direction.sv
// One direction of the transceiver: latch/flip-flop storage and output stage
`timescale 1ns/1ns
module blrt_direction
  import blrt_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Direction controls
  input  wire logic              latch_enable,
  input  wire logic              clock_n,
  input  wire logic              clock_enable_n,
  input  wire logic              output_enable_n,
  // Data
  input  wire logic [DATA_W-1:0] din,
  output logic      [DATA_W-1:0] dout_reg,
  output logic                   oe_reg,
  output logic      [DATA_W-1:0] store_reg
);

  logic              clk_prev_reg;
  logic              clk_fall;
  logic              capture;
  logic [DATA_W-1:0] store_next;

  // Falling edge seen as a level change between two aclk samples
  assign clk_fall = clk_prev_reg & ~clock_n;
  assign capture = ~latch_enable & ~clock_enable_n & clk_fall;
  assign store_next = (latch_enable | capture) ? din : store_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_reg <= CLK_N_RESET;
      store_reg    <= STORE_RESET;
      dout_reg     <= STORE_RESET;
      oe_reg       <= 1'b0;
    end else begin
      clk_prev_reg <= clock_n;
      store_reg    <= store_next;
      dout_reg     <= store_next;
      oe_reg       <= ~output_enable_n;
    end
  end

  property p_width;
    @(posedge aclk) disable iff (!aresetn)
      (store_reg != $past(store_reg)) |-> ($past(latch_enable) || $past(capture));
  endproperty
  a_width: assert property (p_width) else $error("storage changed without latch or capture");

  property p_transparent;
    @(posedge aclk) disable iff (!aresetn)
      (latch_enable && !output_enable_n) |=> (dout_reg == $past(din)) && oe_reg;
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent value not driven");

  property p_latched_high;
    @(posedge aclk) disable iff (!aresetn)
      (!latch_enable && clock_n && clk_prev_reg) |=> $stable(store_reg) && (dout_reg == $past(store_reg));
  endproperty
  a_latched_high: assert property (p_latched_high) else $error("latched value moved with clock high");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
      (!latch_enable && !clock_enable_n && clk_prev_reg && !clock_n)
        |=> (store_reg == $past(din)) && (dout_reg == $past(din));
  endproperty
  a_capture: assert property (p_capture) else $error("falling clock did not capture");

  property p_gated;
    @(posedge aclk) disable iff (!aresetn)
      (!latch_enable && clock_enable_n) [*2] |=> $stable(store_reg);
  endproperty
  a_gated: assert property (p_gated) else $error("gated clock still captured");

  property p_float;
    @(posedge aclk) disable iff (!aresetn)
      output_enable_n |=> !oe_reg ##1 (oe_reg == !$past(output_enable_n));
  endproperty
  a_float: assert property (p_float) else $error("output enable misbehaves");

  property p_low_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!latch_enable && !clock_enable_n && !clock_n && !clk_prev_reg) |=> (store_reg == $past(store_reg));
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("held-low clock captured data");

endmodule // blrt_direction

// >>> verif/blrt_bus_model.sv
// Far-side bus logic model for the A and B buses
`timescale 1ns/1ns
module blrt_bus_model
  import blrt_pkg::*;
(
  // Clock
  input  wire logic              aclk,
  // Bench requests
  input  wire logic              a_en,
  input  wire logic [DATA_W-1:0] a_val,
  input  wire logic              b_en,
  input  wire logic [DATA_W-1:0] b_val,
  // Device pins
  input  wire logic [DATA_W-1:0] a_out,
  input  wire logic [DATA_W-1:0] a_oe,
  input  wire logic [DATA_W-1:0] b_out,
  input  wire logic [DATA_W-1:0] b_oe,
  output logic      [DATA_W-1:0] a_in,
  output logic      [DATA_W-1:0] b_in
);
  logic [DATA_W-1:0] a_last = '0;
  logic [DATA_W-1:0] b_last = '0;
  // Undriven bus toggles so a stale level never passes
  wire  [DATA_W-1:0] a_far = a_en ? a_val : ~a_last;
  wire  [DATA_W-1:0] b_far = b_en ? b_val : ~b_last;
  assign a_in = (a_oe & a_out) | (~a_oe & a_far);
  assign b_in = (b_oe & b_out) | (~b_oe & b_far);
  always @(posedge aclk) begin
    a_last <= a_in;
    b_last <= b_in;
  end
endmodule // blrt_bus_model

// >>> verif/test_blrt_transceiver.sv
// Self-checking bench for the transceiver over AXI4-Lite
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_blrt_transceiver
  import blrt_pkg::*;
;
  logic              aclk, aresetn, a_en, b_en;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [AXI_SW-1:0] s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe, a_val, b_val;
  int                failures, comparisons;

  blrt_transceiver blrt_transceiver_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe
  );
  blrt_bus_model blrt_bus_model_inst (
    .aclk, .a_en, .a_val, .b_en, .b_val, .a_out, .a_oe, .b_out, .b_oe, .a_in, .b_in
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic test_done();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Handshake edge is the posedge after a settled negedge sample
  task automatic wr(input logic [AXI_AW-1:0] ad, input logic [AXI_DW-1:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle limit here; the watchdog ends a hang
    forever begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bvalid === 1'b1;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    `CHK(rsp, er)
  endtask

  task automatic chk_rd(input logic [AXI_AW-1:0] ad, input logic [AXI_DW-1:0] ed, input logic [1:0] er);
    logic ar_hit, r_hit;
    logic [AXI_DW-1:0] d;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    `CHK(d, ed)
    `CHK(rsp, er)
  endtask

  function automatic logic [AXI_DW-1:0] ctrl_word(input int ln, input logic [3:0] own);
    return ln == 0 ? {20'h0, 4'hd, 4'h0, own} : {20'h0, own, 4'h0, 4'hd};
  endfunction

  task automatic cw(input int ln, input logic [3:0] own);
    wr(OFS_CTRL, ctrl_word(ln, own), RESP_OKAY);
  endtask

  task automatic src(input int ln, input logic [DATA_W-1:0] v);
    @(posedge aclk);
    if (ln == 0) a_val <= v;
    else b_val <= v;
  endtask

  // Output settles one edge after a control or input change
  task automatic chk_out(input int ln, input logic [DATA_W-1:0] v, input logic oe);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    `CHK(ln == 0 ? b_out : a_out, v)
    `CHK(ln == 0 ? b_oe : a_oe, {DATA_W{oe}})
    @(posedge aclk);
  endtask

  // Control nibble: bit0 oe_n, bit1 le, bit2 clk_n, bit3 cen_n
  task automatic lane(input int ln);
    @(posedge aclk);
    a_en <= ln == 0;
    b_en <= ln == 1;
    src(ln, 18'h2a5a5);
    cw(ln, 4'he);
    chk_out(ln, 18'h2a5a5, 1'b1);
    src(ln, 18'h15a5a);
    chk_out(ln, 18'h15a5a, 1'b1);
    chk_rd(ln == 0 ? OFS_A_PINS : OFS_B_PINS, 32'h15a5a, RESP_OKAY);
    cw(ln, 4'h4);
    src(ln, 18'h3c3c3);
    chk_out(ln, 18'h15a5a, 1'b1);
    chk_rd(ln == 0 ? OFS_AB_STORE : OFS_BA_STORE, 32'h15a5a, RESP_OKAY);
    cw(ln, 4'h0);
    chk_out(ln, 18'h3c3c3, 1'b1);
    src(ln, 18'h0ff00);
    cw(ln, 4'h4);
    chk_out(ln, 18'h3c3c3, 1'b1);
    cw(ln, 4'hc);
    cw(ln, 4'h8);
    chk_out(ln, 18'h3c3c3, 1'b1);
    cw(ln, 4'h2);
    chk_out(ln, 18'h0ff00, 1'b1);
    cw(ln, 4'h0);
    src(ln, 18'h30f0f);
    chk_out(ln, 18'h0ff00, 1'b1);
    cw(ln, 4'h1);
    chk_out(ln, 18'h0ff00, 1'b0);
    cw(ln, 4'hd);
    $display("test lane %0d done", ln);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    {a_en, b_en} = '0;
    a_val = '0;
    b_val = '0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(a_oe | b_oe, 18'h0)
    chk_rd(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    chk_rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h0, RESP_SLVERR);
    wr(OFS_AB_STORE, 32'h3ffff, RESP_OKAY);
    chk_rd(OFS_AB_STORE, 32'h0, RESP_OKAY);
    $display("test reset and map done");
    lane(0);
    lane(1);
    chk_rd(OFS_AB_STORE, 32'h0ff00, RESP_OKAY);
    chk_rd(OFS_CTRL, 32'h0d0d, RESP_OKAY);
    test_done();
  end

  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule // test_blrt_transceiver
